/* File: ebt_pkg.sv */
// Package of constants and types for the eight-bit timer run control block.
package ebt_pkg;

	// Number of timers and their order: 0, 1, 8, 9, A, B.
	localparam int NUM_TIMERS = 6;
	localparam int NUM_PAIRS = 3;
	localparam int IDX_T9 = 3;
	localparam int IDX_TB = 5;

	// Run-control register byte addresses, indexed in timer order.
	localparam logic [0:5][15:0] RUN_ADDR = {
		16'hf033, 16'hf037, 16'hf8e3, 16'hf8e7, 16'hf8eb, 16'hf8ef
	};
	localparam logic [15:0] TB_CFG_ADDR = 16'hf8ee;

	// Supporting registers: compare values, counters, pairing, interrupts.
	localparam logic [15:0] CMP_BASE = 16'hf900;
	localparam logic [15:0] CNT_BASE = 16'hf920;
	localparam logic [15:0] CASCADE_ADDR = 16'hf910;
	localparam logic [15:0] IRQ_STATUS_ADDR = 16'hf911;
	localparam logic [15:0] IRQ_MASK_ADDR = 16'hf912;

	// Field positions.
	localparam int GO_BIT = 0;
	localparam int COUNTING_BIT = 7;
	localparam int CASCADE_AB_BIT = 2;

	// Values after reset, and the counter's top value.
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [5:0] IRQ_RESET = 6'h00;
	localparam logic [2:0] CASCADE_RESET = 3'h0;

	// Count clock choices of timer B.
	typedef enum logic [1:0] {
		EBT_CLK_LOW_SPEED = 2'b00,
		EBT_CLK_TIMEBASE = 2'b01,
		EBT_CLK_NONE = 2'b10,
		EBT_CLK_EXT_PIN = 2'b11
	} ebt_clk_sel_e;

	// Timer B clock and mode configuration layout.
	typedef struct packed {
		logic tb_single_shot;
		logic tb_out_invert;
		logic [3:0] reserved;
		ebt_clk_sel_e clk_sel;
	} ebt_tbcfg_s;

	localparam ebt_tbcfg_s TBCFG_RESET = '{
		tb_single_shot: 1'b0,
		tb_out_invert: 1'b0,
		reserved: 4'h0,
		clk_sel: EBT_CLK_LOW_SPEED
	};

endpackage

/* File: ebt_run_control.sv */
// Run control, timer B configuration and counting logic of six 8-bit timers.
//
// Notes on behaviour
// [R1] Software reconfigures timer B only when stopped.
// [R2] Timer B clock select chooses its count clock.
// [R3] Pair cascade ignores timer B clock select.
// [R4] Polarity bit sets timer B output sense.
// [R5] Mode bit selects repeating or one-shot operation.
// [R6] Go bit writes start or stop counting.
// [R7] Counting bit reads running state of timer.
// [R8] Software keeps upper go bit zero when cascaded.
// [R9] Cascaded upper timer counts lower timer overflows.
// [R10] Cascaded upper timer counting bit reads zero.
// [R11] Reset clears all control and configuration registers.
// [R12] First edge sets counting, second edge increments.
// [R13] Match: next edge interrupts, clears counter, continues.
// [R14] Timer 9 and B outputs toggle per match.
// [R15] One-shot mode clears go bit on match.
//
// Timer B's configuration is not locked while it counts; software must
// stop it first, since a clock switch mid-count can fake a count edge.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps

module ebt_run_control (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_low_speed_clk,
	input wire logic i_timebase_clk,
	input wire logic i_ext_count_clk_pin,
	output logic o_t9_toggle_out,
	output logic o_tb_toggle_out,
	output logic o_irq
);

	// Short names for the timer count and the two timers with outputs.
	localparam int N = ebt_pkg::NUM_TIMERS;
	localparam int TB = ebt_pkg::IDX_TB;
	localparam int T9 = ebt_pkg::IDX_T9;

	////////////////////////////////////////////////////////////////////////
	// Count clock synchronisers and falling edge detection.

	// Bit 0 is the low-speed clock, bit 1 the time base, bit 2 the pin.
	logic [2:0] clk_meta;
	logic [2:0] clk_sync;
	logic [2:0] clk_prev;
	logic [2:0] clk_fall;

	// Three flops per clock input; the edge detector compares the second and the third.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			clk_meta <= 3'h0;
			clk_sync <= 3'h0;
			clk_prev <= 3'h0;
		end else begin
			clk_meta <= {i_ext_count_clk_pin, i_timebase_clk, i_low_speed_clk};
			clk_sync <= clk_meta;
			clk_prev <= clk_sync;
		end
	end

	// Every timer outside a cascaded upper one counts on falling edges of its count clock.
	assign clk_fall = clk_prev & ~clk_sync;

	////////////////////////////////////////////////////////////////////////
	// Register state.

	// Control and data state of all six timers, in timer order.
	ebt_pkg::ebt_tbcfg_s tb_cfg;
	logic [N-1:0] go;
	logic [N-1:0] counting;
	logic [N-1:0][7:0] cnt;
	logic [N-1:0][7:0] cmp;
	logic [2:0] cascade;
	logic [5:0] irq_status;
	logic [5:0] irq_mask;

	// Timer B configuration; the clock select is a plain two-bit field.
	// Software is trusted to change it only while timer B is stopped, since
	// a switch mid-count could produce a spurious edge.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			tb_cfg <= ebt_pkg::TBCFG_RESET; // [R11]
		end else if (i_wr && i_addr == ebt_pkg::TB_CFG_ADDR) begin
			tb_cfg.tb_single_shot <= i_wdata[7];
			tb_cfg.tb_out_invert <= i_wdata[6];
			tb_cfg.clk_sel <= ebt_pkg::ebt_clk_sel_e'(i_wdata[1:0]);
		end
	end

	// Pair cascade bits, one per pair, and the interrupt mask.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			cascade <= ebt_pkg::CASCADE_RESET;
			irq_mask <= ebt_pkg::IRQ_RESET;
		end else if (i_wr && i_addr == ebt_pkg::CASCADE_ADDR) begin
			cascade <= i_wdata[2:0];
		end else if (i_wr && i_addr == ebt_pkg::IRQ_MASK_ADDR) begin
			irq_mask <= i_wdata[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Count advance, overflow and match per timer.

	// Combinational view of each timer's count enable and events.
	logic [N-1:0] is_upper_casc;
	logic [N-1:0] base_tick;
	logic [N-1:0] tick;
	logic [N-1:0] active;
	logic [N-1:0] ovf;
	logic [N-1:0] evt;
	logic [N-1:0] running;
	logic tb_tick;

	// Timer B picks its own count clock; code 10 gives no edges at all.
	always_comb begin
		case (tb_cfg.clk_sel)
			ebt_pkg::EBT_CLK_LOW_SPEED: tb_tick = clk_fall[0]; // [R2]
			ebt_pkg::EBT_CLK_TIMEBASE: tb_tick = clk_fall[1]; // [R2]
			ebt_pkg::EBT_CLK_EXT_PIN: tb_tick = clk_fall[2]; // [R2]
			default: tb_tick = 1'b0; // [R2]
		endcase
	end

	// The lower timer of a cascaded pair wraps freely and hands its
	// overflow to the upper one, which then ignores its own run bit.
	always_comb begin
		is_upper_casc = '0;
		base_tick = '0;
		tick = '0;
		active = '0;
		ovf = '0;
		evt = '0;
		running = '0;
		for (int i = 0; i < N; i++) begin
			is_upper_casc[i] = (i % 2 == 1) && cascade[i/2];
			base_tick[i] = (i == TB) ? tb_tick : clk_fall[0];
		end
		// A cascaded lower timer raises no match event of its own.
		for (int i = 0; i < N; i += 2) begin
			tick[i] = base_tick[i];
			active[i] = counting[i];
			ovf[i] = tick[i] && counting[i] && cascade[i/2] &&
				cnt[i] == ebt_pkg::CNT_MAX;
			running[i] = counting[i];
			evt[i] = tick[i] && counting[i] && !cascade[i/2] &&
				cnt[i] == cmp[i]; // [R13]
		end
		for (int i = 1; i < N; i += 2) begin
			// Cascade overrides timer B clock select entirely.
			tick[i] = is_upper_casc[i] ? ovf[i-1] : base_tick[i]; // [R3] [R9]
			active[i] = is_upper_casc[i] || counting[i]; // [R9]
			running[i] = is_upper_casc[i] ? counting[i-1] : counting[i];
			evt[i] = tick[i] && active[i] && cnt[i] == cmp[i]; // [R13]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per timer go bit, counting bit, counter and compare value.

	// Each timer gets its own copy of the control flops; the loop index
	// also picks its run-control address from the package table.
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_timer
			logic wr_run;
			logic wr_cmp;
			logic wr_cnt;
			logic one_shot_hit;

			// Decode of this timer's own registers.
			assign wr_run = i_wr && i_addr == ebt_pkg::RUN_ADDR[g];
			assign wr_cmp = i_wr && i_addr == ebt_pkg::CMP_BASE + 16'(g);
			assign wr_cnt = i_wr && i_addr == ebt_pkg::CNT_BASE + 16'(g);
			// Only timer B's mode bit lives in this block.
			assign one_shot_hit = (g == TB) && tb_cfg.tb_single_shot &&
				evt[g];

			// A software write wins over the automatic one-shot clear so a
			// restart written on the matching cycle is not dropped.
			always_ff @(posedge i_ref_clk) begin
				if (!i_reset_n) begin
					go[g] <= 1'b0; // [R11]
				end else if (wr_run) begin
					go[g] <= i_wdata[ebt_pkg::GO_BIT]; // [R6]
				end else if (one_shot_hit) begin
					go[g] <= 1'b0; // [R5] [R15]
				end
			end

			// Counting follows go on each count edge, so a stop still
			// lets one more edge be counted.
			always_ff @(posedge i_ref_clk) begin
				if (!i_reset_n) begin
					counting[g] <= 1'b0; // [R11]
				end else if (is_upper_casc[g]) begin
					counting[g] <= 1'b0; // [R10]
				end else if (base_tick[g]) begin
					counting[g] <= go[g] && !one_shot_hit; // [R7] [R12]
				end
			end

			// Outside a cascaded upper timer, the counter only moves once counting is set, which
			// puts the first increment on the second count edge.
			always_ff @(posedge i_ref_clk) begin
				if (!i_reset_n) begin
					cnt[g] <= ebt_pkg::CNT_RESET;
				end else if (wr_cnt) begin
					cnt[g] <= ebt_pkg::CNT_RESET;
				end else if (tick[g] && active[g]) begin
					if (evt[g]) begin
						cnt[g] <= ebt_pkg::CNT_RESET; // [R13]
					end else begin
						cnt[g] <= cnt[g] + 8'h01; // [R12] [R9]
					end
				end
			end

			// Compare value written by software.
			always_ff @(posedge i_ref_clk) begin
				if (!i_reset_n) begin
					cmp[g] <= ebt_pkg::REG_RESET;
				end else if (wr_cmp) begin
					cmp[g] <= i_wdata;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Toggle outputs of timers 9 and B.

	// Internal toggle state, before the polarity is applied.
	logic t9_tog;
	logic tb_tog;

	// Both toggles return to zero while their timer is not running.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			t9_tog <= 1'b0; // [R14]
			tb_tog <= 1'b0; // [R14]
		end else begin
			if (!running[T9]) begin
				t9_tog <= 1'b0; // [R14]
			end else if (evt[T9]) begin
				t9_tog <= !t9_tog; // [R14]
			end
			if (!running[TB]) begin
				tb_tog <= 1'b0; // [R14]
			end else if (evt[TB]) begin
				tb_tog <= !tb_tog; // [R14]
			end
		end
	end

	// Output flops; polarity inverts only the pin sense, not the toggle.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_t9_toggle_out <= 1'b0;
			o_tb_toggle_out <= 1'b0;
		end else begin
			o_t9_toggle_out <= t9_tog;
			o_tb_toggle_out <= tb_tog ^ tb_cfg.tb_out_invert; // [R4]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and output.

	logic [5:0] irq_clr;

	// Write-one-to-clear pattern taken from a status write.
	assign irq_clr = (i_wr && i_addr == ebt_pkg::IRQ_STATUS_ADDR) ?
		i_wdata[5:0] : 6'h00;

	// Sticky status; an event in the clearing cycle survives the clear.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			irq_status <= ebt_pkg::IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | evt; // [R13]
		end
	end

	// Level interrupt from a flop, so the pin never glitches; it trails
	// the status bit by one cycle.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path: data stand in the cycle after the strobe, zero otherwise.

	// Byte selected by the address, ahead of the read data flop.
	logic [7:0] rd_value;

	always_comb begin
		rd_value = 8'h00;
		for (int i = 0; i < N; i++) begin
			if (i_addr == ebt_pkg::RUN_ADDR[i]) begin
				rd_value = {counting[i], 6'h00, go[i]}; // [R7] [R10]
			end else if (i_addr == ebt_pkg::CMP_BASE + 16'(i)) begin
				rd_value = cmp[i];
			end else if (i_addr == ebt_pkg::CNT_BASE + 16'(i)) begin
				rd_value = cnt[i];
			end
		end
		if (i_addr == ebt_pkg::TB_CFG_ADDR) begin
			rd_value = {tb_cfg.tb_single_shot, tb_cfg.tb_out_invert, 4'h0,
				tb_cfg.clk_sel};
		end else if (i_addr == ebt_pkg::CASCADE_ADDR) begin
			rd_value = {5'h00, cascade};
		end else if (i_addr == ebt_pkg::IRQ_STATUS_ADDR) begin
			rd_value = {2'h0, irq_status};
		end else if (i_addr == ebt_pkg::IRQ_MASK_ADDR) begin
			rd_value = {2'h0, irq_mask};
		end
	end

	// Read data hold the byte for exactly one cycle and are zero otherwise,
	// so a late sample sees nothing rather than a stale value.
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rd_value;
		end else begin
			o_rdata <= 8'h00;
		end
	end

endmodule

/* File: ebt_run_control_assertions.sv */
// Port checks for the timer run control block.
`timescale 1ns/1ps
module ebt_run_control_assertions (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_t9_toggle_out,
	input wire logic o_tb_toggle_out,
	input wire logic o_irq
);
	// One clock domain, so clock and reset are given once.
	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);

	////////////////////////////////////////
	// Read data and reset levels.
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside a read");
	reset_irq_a: assert property ($rose(i_reset_n) |-> !o_irq)
		else $error("interrupt high after reset");
	reset_pins_a: assert property ($rose(i_reset_n) |->
		!o_t9_toggle_out && !o_tb_toggle_out)
		else $error("toggle output high after reset");
	run_rsvd_a: assert property (i_rd &&
		i_addr == ebt_pkg::RUN_ADDR[5] |=> o_rdata[6:1] == 6'h00)
		else $error("unused run control bits not zero");
	cfg_rsvd_a: assert property (i_rd &&
		i_addr == ebt_pkg::TB_CFG_ADDR |=> o_rdata[5:2] == 4'h0)
		else $error("unused configuration bits not zero");

	////////////////////////////////////////
	// Write then read back, and masking of the interrupt.
	go_back_a: assert property (i_wr &&
		i_addr == ebt_pkg::RUN_ADDR[0] ##1 !i_wr ##1 i_rd &&
		i_addr == ebt_pkg::RUN_ADDR[0] |=>
		(o_rdata & 8'h01) == ($past(i_wdata, 3) & 8'h01))
		else $error("go bit does not read back");
	cfg_back_a: assert property (i_wr &&
		i_addr == ebt_pkg::TB_CFG_ADDR ##1 !i_wr ##1 i_rd &&
		i_addr == ebt_pkg::TB_CFG_ADDR |=>
		(o_rdata & 8'hc3) == ($past(i_wdata, 3) & 8'hc3))
		else $error("configuration does not read back");
	mask_off_a: assert property (i_wr &&
		i_addr == ebt_pkg::IRQ_MASK_ADDR && i_wdata[5:0] == 6'h00 ##1
		!(i_wr && i_addr == ebt_pkg::IRQ_MASK_ADDR) |=> !o_irq)
		else $error("interrupt high with all sources masked");
endmodule

bind ebt_run_control ebt_run_control_assertions u_chk (
	.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_t9_toggle_out(o_t9_toggle_out),
	.o_tb_toggle_out(o_tb_toggle_out), .o_irq(o_irq)
);

/* File: ebt_run_control_tb.sv */
// Self-checking testbench of the timer run control block.
`timescale 1ns/1ps
module ebt_run_control_tb;
	logic i_ref_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_low_speed_clk = 1'b0;
	logic i_timebase_clk = 1'b0;
	logic i_ext_count_clk_pin = 1'b0;
	logic [7:0] o_rdata;
	logic o_t9_toggle_out;
	logic o_tb_toggle_out;
	logic o_irq;
	logic chk = 1'b0;
	logic pend = 1'b0;
	logic [7:0] cyc = 8'h00;
	logic [16:0] lf = 17'h13220; // Seed 78368.
	logic [7:0] rv;
	logic [7:0] q[$];
	int num_errors = 0;
	int n_tests = 0;
	int i;

	ebt_run_control u_dut (
		.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_low_speed_clk(i_low_speed_clk),
		.i_timebase_clk(i_timebase_clk),
		.i_ext_count_clk_pin(i_ext_count_clk_pin),
		.o_t9_toggle_out(o_t9_toggle_out),
		.o_tb_toggle_out(o_tb_toggle_out), .o_irq(o_irq)
	);

	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	// The expected byte is queued when the read is issued.
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		chk <= 1'b1;
		q.push_back(e);
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
	endtask

	// Polls bypass the queue; running out of tries ends the run.
	task automatic poll(input logic [15:0] a, input logic [7:0] m,
		input logic [7:0] v, input int n);
		int k;
		logic [7:0] g;
		g = ~v;
		for (k = 0; k < n && (g & m) !== v; k++) begin
			@(posedge i_ref_clk);
			i_addr <= a;
			i_rd <= 1'b1;
			chk <= 1'b0;
			@(posedge i_ref_clk);
			i_rd <= 1'b0;
			@(negedge i_ref_clk);
			g = o_rdata;
		end
		chk8("poll", v, g & m);
		if ((g & m) !== v)
			print_verdict();
	endtask

	////////////////////////////////////////
	// Clock of 40 ns.
	initial begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	// Count clocks: slow enough that the 3-cycle sync lag never aliases.
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 8'h01;
		lf <= lfsr(lf);
		i_low_speed_clk <= cyc[3];
		i_timebase_clk <= cyc[1];
		i_ext_count_clk_pin <= lf[0];
	end

	// Read data stands in the cycle after the strobe, so sample mid-cycle.
	always @(posedge i_ref_clk) pend <= i_rd & chk;
	always @(negedge i_ref_clk) begin
		if (pend) begin
			if (q.size() == 0)
				chk8("queue", 8'h00, 8'hff);
			else
				chk8("rdata", q.pop_front(), o_rdata);
		end
	end

	////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		for (i = 0; i < 6; i++)
			rd(ebt_pkg::RUN_ADDR[i], 8'h00);
		rd(ebt_pkg::TB_CFG_ADDR, 8'h00);
		rd(16'hf000, 8'h00);
		rv = lf[7:0];
		wr(ebt_pkg::TB_CFG_ADDR, rv);
		rd(ebt_pkg::TB_CFG_ADDR, rv & 8'hc3);
		wr(ebt_pkg::RUN_ADDR[1], 8'h7e);
		rd(ebt_pkg::RUN_ADDR[1], 8'h00);
		wr(ebt_pkg::CMP_BASE, 8'h02);
		wr(ebt_pkg::IRQ_MASK_ADDR, 8'h01);
		wr(ebt_pkg::RUN_ADDR[0], 8'h01);
		poll(ebt_pkg::RUN_ADDR[0], 8'h81, 8'h81, 40);
		poll(ebt_pkg::IRQ_STATUS_ADDR, 8'h01, 8'h01, 100);
		repeat (2) @(negedge i_ref_clk);
		chk8("irq", 8'h01, {7'h00, o_irq});
		wr(ebt_pkg::IRQ_MASK_ADDR, 8'h00);
		repeat (2) @(negedge i_ref_clk);
		chk8("irq", 8'h00, {7'h00, o_irq});
		wr(ebt_pkg::RUN_ADDR[0], 8'h00);
		poll(ebt_pkg::RUN_ADDR[0], 8'h81, 8'h00, 40);
		wr(ebt_pkg::IRQ_STATUS_ADDR, 8'h01);
		rd(ebt_pkg::IRQ_STATUS_ADDR, 8'h00);
		wr(ebt_pkg::TB_CFG_ADDR, 8'hc0);
		repeat (2) @(negedge i_ref_clk);
		chk8("tb_out", 8'h01, {7'h00, o_tb_toggle_out});
		wr(ebt_pkg::CMP_BASE + 16'h0005, 8'h01);
		wr(ebt_pkg::RUN_ADDR[5], 8'h01);
		poll(ebt_pkg::RUN_ADDR[5], 8'hff, 8'h00, 100);
		rd(ebt_pkg::IRQ_STATUS_ADDR, 8'h20);
		wr(ebt_pkg::TB_CFG_ADDR, 8'h02);
		wr(ebt_pkg::RUN_ADDR[5], 8'h01);
		repeat (100) @(posedge i_ref_clk);
		rd(ebt_pkg::RUN_ADDR[5], 8'h01);
		// Timer 9 toggles on its first match and drops when stopped.
		wr(ebt_pkg::CMP_BASE + 16'h0003, 8'h01);
		wr(ebt_pkg::RUN_ADDR[3], 8'h01);
		poll(ebt_pkg::IRQ_STATUS_ADDR, 8'h08, 8'h08, 100);
		chk8("t9_out", 8'h01, {7'h00, o_t9_toggle_out});
		wr(ebt_pkg::RUN_ADDR[3], 8'h00);
		poll(ebt_pkg::RUN_ADDR[3], 8'h81, 8'h00, 40);
		@(negedge i_ref_clk);
		chk8("t9_out", 8'h00, {7'h00, o_t9_toggle_out});
		// The time base is four times faster than the low-speed clock.
		wr(ebt_pkg::CMP_BASE + 16'h0005, 8'hff);
		wr(ebt_pkg::CNT_BASE + 16'h0005, 8'h00);
		wr(ebt_pkg::TB_CFG_ADDR, 8'h01);
		poll(ebt_pkg::CNT_BASE + 16'h0005, 8'hff, 8'h10, 50);
		wr(ebt_pkg::RUN_ADDR[5], 8'h00);
		wr(ebt_pkg::CMP_BASE + 16'h0005, 8'h05);
		wr(ebt_pkg::CNT_BASE + 16'h0005, 8'h00);
		wr(ebt_pkg::TB_CFG_ADDR, 8'h02);
		wr(ebt_pkg::CASCADE_ADDR, 8'h04);
		wr(ebt_pkg::RUN_ADDR[4], 8'h01);
		poll(ebt_pkg::RUN_ADDR[4], 8'h80, 8'h80, 40);
		rd(ebt_pkg::RUN_ADDR[5], 8'h00);
		poll(ebt_pkg::CNT_BASE + 16'h0005, 8'hff, 8'h01, 2200);
		print_verdict();
	end
endmodule
